// file: core/fec_flash_erase_ctrl.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module fec_flash_erase_ctrl
  import fec_pkg::*;
#(
  parameter int WINDOW_CYCLES = WINDOW_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [7:0] rdata,
  input wire logic [7:0] primary_sector_selects,
  input wire logic [3:0] secondary_sector_selects,
  input wire logic sram_select,
  input wire logic io_select,
  input wire logic [7:0] primary_rdata,
  input wire logic [7:0] secondary_rdata,
  input wire logic [7:0] sram_rdata,
  input wire logic [7:0] io_rdata,
  input wire logic [11:0] sector_protect,
  input wire logic erase_verify_ok,
  input wire logic reset_pin_n,
  output logic [11:0] erase_sector_mask,
  output logic erasing,
  output logic error_flag
);

  // ==========================================================
  // state
  typedef struct packed {
    fec_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] hold;
    logic [3:0] att;
    logic [11:0] mask;
    logic toggle;
    logic err;
    logic [7:0] rdata;
    logic [2:0] pin_sync;
    logic pin_low;
    logic erasing;
  } fec_regs_t;

  localparam logic [CNT_W-1:0] WIN_LOAD = CNT_W'(WINDOW_CYCLES);
  localparam logic [CNT_W-1:0] ERASE_LOAD = CNT_W'(ERASE_CYCLES);
  localparam logic [CNT_W-1:0] REC_LOAD = CNT_W'(RECOVER_CYC);
  localparam logic [CNT_W-1:0] SUS_LOAD = CNT_W'(SUSPEND_CYC);
  localparam logic [3:0] ATT_MAX = 4'(MAX_ATTEMPTS);

  fec_regs_t state_reg;
  fec_regs_t state_next;

  // ==========================================================
  // helpers
  // effective sector vector {secondary, primary} after overlap priority
  function automatic logic [11:0] eff_sel(input logic [7:0] pri, input logic [3:0] sec,
                                          input logic sram, input logic io);
    logic [11:0] v;
    v = MASK_NONE;
    if (!(sram || io)) begin
      if (|sec) begin
        v = {sec, 8'h00};
      end else begin
        v = {4'h0, pri};
      end
    end
    return v;
  endfunction

  function automatic logic cmd_at(input logic [7:0] d, input logic [11:0] a,
                                  input logic [7:0] dc, input logic [11:0] ac);
    return (d == dc) && (a == ac);
  endfunction

  logic [11:0] sel;
  logic any_sel;
  logic even_sel;
  logic pin_fall_cond;

  always_comb begin
    sel = eff_sel(primary_sector_selects, secondary_sector_selects, sram_select, io_select);
    any_sel = |sel;
    even_sel = any_sel && !addr[0];
  end

  // ==========================================================
  // next state
  always_comb begin
    logic busy;
    logic status_hit;
    logic [7:0] st_byte;
    busy = 1'b0;
    status_hit = 1'b0;
    st_byte = STATUS_BASE;
    pin_fall_cond = 1'b0;
    state_next = state_reg;
    state_next.pin_sync = {state_reg.pin_sync[1:0], reset_pin_n};
    // pin level changes once second and third stages agree
    if (state_reg.pin_sync[1] == state_reg.pin_sync[2]) begin
      state_next.pin_low = !state_reg.pin_sync[2];
    end
    pin_fall_cond = state_next.pin_low && !state_reg.pin_low;

    // ---------------- read path
    busy = (state_reg.st == ST_WINDOW) || (state_reg.st == ST_SECT) ||
           (state_reg.st == ST_BULK) || (state_reg.st == ST_SUSPENDING) ||
           (state_reg.st == ST_FAIL);
    status_hit = busy && |(sel & state_reg.mask);
    if (state_reg.st == ST_BULK) begin
      status_hit = any_sel;
    end
    st_byte[BIT_POLL] = 1'b0;
    st_byte[BIT_TOGGLE] = state_reg.toggle;
    st_byte[BIT_ERROR] = state_reg.err;
    st_byte[BIT_TIMEOUT] = (state_reg.st != ST_WINDOW);
    if (rd_strobe) begin
      if (sram_select) begin
        state_next.rdata = sram_rdata;
      end else if (io_select) begin
        state_next.rdata = io_rdata;
      end else if (status_hit) begin
        state_next.rdata = st_byte;
        state_next.toggle = !state_reg.toggle;
      end else if ((state_reg.st == ST_SUSPENDED) && |(sel & state_reg.mask)) begin
        state_next.rdata = INVALID_DATA;
      end else if (|secondary_sector_selects) begin
        state_next.rdata = secondary_rdata;
      end else begin
        state_next.rdata = primary_rdata;
      end
    end

    // ---------------- timers
    if (state_reg.cnt != CNT_ZERO) begin
      state_next.cnt = state_reg.cnt - CNT_ONE;
    end

    unique case (state_reg.st)
      ST_READ: begin
        if (wr_strobe) begin
          if (cmd_at(wdata, addr, CMD_UNLOCK1, ADDR_UNLOCK1)) begin
            state_next.st = ST_U1;
          end else if (wdata == CMD_RESET) begin
            state_next.err = 1'b0;
          end
        end
      end
      ST_U1: begin
        if (wr_strobe) begin
          state_next.st = cmd_at(wdata, addr, CMD_UNLOCK2, ADDR_UNLOCK2) ? ST_U2 : ST_READ;
        end
      end
      ST_U2: begin
        if (wr_strobe) begin
          if (cmd_at(wdata, addr, CMD_ERASE_SETUP, ADDR_UNLOCK1)) begin
            state_next.st = ST_SETUP;
          end else begin
            state_next.st = ST_READ;
          end
        end
      end
      ST_SETUP: begin
        if (wr_strobe) begin
          state_next.st = cmd_at(wdata, addr, CMD_UNLOCK1, ADDR_UNLOCK1) ? ST_U3 : ST_READ;
        end
      end
      ST_U3: begin
        if (wr_strobe) begin
          state_next.st = cmd_at(wdata, addr, CMD_UNLOCK2, ADDR_UNLOCK2) ? ST_U4 : ST_READ;
        end
      end
      ST_U4: begin
        if (wr_strobe) begin
          state_next.st = ST_READ;
          if (cmd_at(wdata, addr, CMD_BULK, ADDR_UNLOCK1)) begin
            state_next.st = ST_BULK;
            state_next.mask = MASK_ALL & ~sector_protect;
            state_next.cnt = ERASE_LOAD;
            state_next.att = ATT_ONE;
            state_next.err = 1'b0;
            state_next.erasing = 1'b1;
          end else if ((wdata == CMD_SECTOR) && any_sel) begin
            state_next.st = ST_WINDOW;
            state_next.mask = sel & ~sector_protect;
            state_next.cnt = WIN_LOAD;
            state_next.err = 1'b0;
          end
        end
      end
      ST_WINDOW: begin
        if (wr_strobe) begin
          if ((wdata == CMD_SECTOR) && any_sel) begin
            state_next.mask = state_reg.mask | (sel & ~sector_protect);
            state_next.cnt = WIN_LOAD;
          end else if ((wdata == CMD_SUSPEND) && even_sel) begin
            state_next.st = ST_SUSPENDING;
            state_next.cnt = SUS_LOAD;
          end else begin
            state_next.st = ST_READ;
            state_next.mask = MASK_NONE;
          end
        end else if (state_reg.cnt == CNT_ZERO) begin
          state_next.st = ST_SECT;
          state_next.cnt = ERASE_LOAD;
          state_next.att = ATT_ONE;
          state_next.erasing = 1'b1;
        end
      end
      ST_SECT, ST_BULK: begin
        if (wr_strobe && (state_reg.st == ST_SECT)) begin
          if ((wdata == CMD_SUSPEND) && even_sel) begin
            state_next.st = ST_SUSPENDING;
            // the suspend timer reuses cnt, so park what is left of the attempt
            state_next.hold = state_reg.cnt;
            state_next.cnt = SUS_LOAD;
            state_next.erasing = 1'b0;
          end else if (wdata == CMD_RESET) begin
            state_next.st = ST_RECOVER;
            state_next.cnt = REC_LOAD;
            state_next.erasing = 1'b0;
          end
        end else if (state_reg.cnt == CNT_ZERO) begin
          if (erase_verify_ok) begin
            state_next.st = ST_READ;
            state_next.mask = MASK_NONE;
            state_next.erasing = 1'b0;
          end else if (state_reg.att == ATT_MAX) begin
            state_next.st = ST_FAIL;
            state_next.err = 1'b1;
            state_next.erasing = 1'b0;
          end else begin
            state_next.att = state_reg.att + ATT_ONE;
            state_next.cnt = ERASE_LOAD;
          end
        end
      end
      ST_SUSPENDING: begin
        if (state_reg.cnt == CNT_ZERO) begin
          state_next.st = ST_SUSPENDED;
        end
      end
      ST_SUSPENDED: begin
        if (wr_strobe) begin
          if ((wdata == CMD_RESUME) && even_sel) begin
            state_next.st = ST_SECT;
            state_next.erasing = 1'b1;
            if (state_reg.att == ATT_ZERO) begin
              state_next.cnt = ERASE_LOAD;
              state_next.att = ATT_ONE;
            end else begin
              // continue the interrupted attempt where it stopped
              state_next.cnt = state_reg.hold;
            end
          end else if (wdata == CMD_RESET) begin
            state_next.st = ST_READ;
            state_next.mask = MASK_NONE;
          end
        end
      end
      ST_FAIL: begin
        if (wr_strobe && (wdata == CMD_RESET)) begin
          state_next.st = ST_RECOVER;
          state_next.cnt = REC_LOAD;
        end
      end
      ST_RECOVER: begin
        if (state_reg.cnt == CNT_ZERO) begin
          state_next.st = ST_READ;
          state_next.mask = MASK_NONE;
          state_next.err = 1'b0;
        end
      end
    endcase

    // window-suspended erase has not started any attempt yet
    if ((state_reg.st == ST_WINDOW) && (state_next.st == ST_SUSPENDING)) begin
      state_next.att = ATT_ZERO;
    end

    // reset pin overrides command state, queue, erasing and error flag; the read path still runs
    if (state_next.pin_low) begin
      state_next.erasing = 1'b0;
      state_next.mask = MASK_NONE;
      state_next.err = 1'b0;
      if (pin_fall_cond && (state_reg.erasing || state_reg.st == ST_SUSPENDING)) begin
        state_next.st = ST_RECOVER;
        state_next.cnt = REC_LOAD;
      end else if (state_reg.st != ST_RECOVER) begin
        state_next.st = ST_READ;
        state_next.cnt = CNT_ZERO;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '{st: ST_READ, cnt: CNT_ZERO, hold: CNT_ZERO, att: ATT_ZERO,
                     mask: MASK_NONE,
                     toggle: 1'b0, err: 1'b0, rdata: 8'h00, pin_sync: 3'h7,
                     pin_low: 1'b0, erasing: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;
  assign erase_sector_mask = state_reg.mask;
  assign erasing = state_reg.erasing;
  assign error_flag = state_reg.err;

endmodule

// file: core/fec_pkg.sv
package fec_pkg;
  // ==========================================================
  // command codes and unlock addresses
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'hAAA;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h554;
  // ==========================================================
  // status bit positions and fill values
  localparam int BIT_POLL = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_ERROR = 5;
  localparam int BIT_TIMEOUT = 3;
  localparam logic [7:0] INVALID_DATA = 8'h00;
  localparam logic [7:0] STATUS_BASE = 8'h00;
  localparam logic [11:0] MASK_NONE = 12'h000;
  localparam logic [11:0] MASK_ALL = 12'hFFF;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int WINDOW_US = 100;
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam int RECOVER_US = 25;
  localparam int RECOVER_CYC = RECOVER_US * CLK_MHZ;
  localparam int SUSPEND_NS = 1000;
  localparam int SUSPEND_CYC = (SUSPEND_NS * CLK_MHZ) / 1000;
  localparam int ERASE_CYC_DEF = 50000;
  localparam int MAX_ATTEMPTS = 4;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [3:0] ATT_ZERO = 4'h0;
  localparam logic [3:0] ATT_ONE = 4'h1;

  typedef enum logic [3:0] {
    ST_READ, ST_U1, ST_U2, ST_SETUP, ST_U3, ST_U4, ST_WINDOW,
    ST_SECT, ST_BULK, ST_SUSPENDING, ST_SUSPENDED, ST_FAIL, ST_RECOVER
  } fec_state_t;
endpackage

// file: bench/fec_array_model.sv
`timescale 1ns/100ps
module fec_array_model
  import fec_pkg::*;
(
  input wire logic fail_all,
  output logic [7:0] primary_rdata,
  output logic [7:0] secondary_rdata,
  output logic [7:0] sram_rdata,
  output logic [7:0] io_rdata,
  output logic erase_verify_ok
);
  // ====
  // array contents
  // one fixed byte per region, so routing shows in read data
  assign primary_rdata = 8'h11;
  assign secondary_rdata = 8'h22;
  assign sram_rdata = 8'h33;
  assign io_rdata = 8'h44;
  assign erase_verify_ok = !fail_all;
endmodule

// file: bench/fec_checker.sv
`timescale 1ns/100ps
module fec_checker
  import fec_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic rd_strobe,
  input wire logic [7:0] rdata,
  input wire logic sram_select,
  input wire logic io_select,
  input wire logic [7:0] sram_rdata,
  input wire logic [7:0] secondary_rdata,
  input wire logic [7:0] primary_sector_selects,
  input wire logic [3:0] secondary_sector_selects,
  input wire logic [11:0] sector_protect,
  input wire logic [11:0] erase_sector_mask,
  input wire logic erasing,
  input wire logic error_flag,
  input wire logic reset_pin_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic hit;
  logic plain;
  // ====
  // read routing
  assign plain = !sram_select && !io_select;
  assign hit = plain && secondary_sector_selects == 4'h0 &&
    (primary_sector_selects & erase_sector_mask[7:0]) != 8'h00;
  a_sram_wins: assert property (rd_strobe && sram_select |=> rdata == $past(sram_rdata))
    else $error("sram read not routed");
  a_sec_over_pri: assert property (rd_strobe && plain && !erasing && !error_flag &&
    erase_sector_mask == MASK_NONE && secondary_sector_selects != 4'h0
    |=> rdata == $past(secondary_rdata)) else $error("secondary read not routed");
  a_rdata_holds: assert property (!rd_strobe |=> $stable(rdata))
    else $error("read data moved without read");
  a_status_bits: assert property (rd_strobe && erasing && hit |=> !rdata[BIT_POLL] &&
    rdata[BIT_TIMEOUT] && rdata[2:0] == 3'h0) else $error("erase status wrong");
  // ====
  // erase control
  a_protect_excl: assert property ((erase_sector_mask & sector_protect) == MASK_NONE)
    else $error("protected sector queued");
  a_pin_abort: assert property (!reset_pin_n [*6] |-> !erasing &&
    erase_sector_mask == MASK_NONE) else $error("reset pin did not abort");
  a_error_source: assert property ($rose(error_flag) |-> $past(erasing))
    else $error("error without erase");
  a_mask_frozen: assert property (erasing && $past(erasing) |-> $stable(erase_sector_mask))
    else $error("queue changed while erasing");
endmodule
bind fec_flash_erase_ctrl fec_checker fec_checker_i (.clk(clk), .resetn(resetn),
  .rd_strobe(rd_strobe), .rdata(rdata), .sram_select(sram_select), .io_select(io_select),
  .sram_rdata(sram_rdata), .secondary_rdata(secondary_rdata),
  .primary_sector_selects(primary_sector_selects),
  .secondary_sector_selects(secondary_sector_selects), .sector_protect(sector_protect),
  .erase_sector_mask(erase_sector_mask), .erasing(erasing), .error_flag(error_flag),
  .reset_pin_n(reset_pin_n));

// file: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import fec_pkg::*;
  logic clk, resetn, wr_strobe, rd_strobe, sram_select, io_select, reset_pin_n, fail_all;
  logic erasing, error_flag, erase_verify_ok;
  logic [11:0] addr, sector_protect, erase_sector_mask;
  logic [7:0] wdata, rdata, primary_sector_selects, primary_rdata, secondary_rdata;
  logic [7:0] sram_rdata, io_rdata;
  logic [3:0] secondary_sector_selects;
  int miscompares, n_tests;
  fec_flash_erase_ctrl #(.WINDOW_CYCLES(50), .ERASE_CYCLES(40)) fec_flash_erase_ctrl_i (
    .clk, .resetn, .addr, .wdata, .wr_strobe, .rd_strobe, .rdata, .primary_sector_selects,
    .secondary_sector_selects, .sram_select, .io_select, .primary_rdata, .secondary_rdata,
    .sram_rdata, .io_rdata, .sector_protect, .erase_verify_ok, .reset_pin_n,
    .erase_sector_mask, .erasing, .error_flag);
  fec_array_model fec_array_model_i (.fail_all, .primary_rdata, .secondary_rdata,
    .sram_rdata, .io_rdata, .erase_verify_ok);
  // ====
  // helpers
  task automatic final_report();
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(string n, logic e, logic g);
    chk(n, {11'h000, e}, {11'h000, g});
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    #1;
  endtask
  task automatic rd(output logic [7:0] v);
    @(posedge clk);
    addr <= 12'h000;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic rdc(string n, logic [7:0] e);
    logic [7:0] v;
    rd(v);
    chk(n, {4'h0, e}, {4'h0, v});
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wait_flag(int s, logic v, int n);
    for (int i = 0; i < n && (s ? error_flag : erasing) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if ((s ? error_flag : erasing) !== v) begin
      chk1("flag wait", v, ~v);
      final_report();
    end
  endtask
  task automatic erase_cmd(logic [11:0] a, logic [7:0] c);
    wr(ADDR_UNLOCK1, CMD_UNLOCK1);
    wr(ADDR_UNLOCK2, CMD_UNLOCK2);
    wr(ADDR_UNLOCK1, CMD_ERASE_SETUP);
    wr(ADDR_UNLOCK1, CMD_UNLOCK1);
    wr(ADDR_UNLOCK2, CMD_UNLOCK2);
    wr(a, c);
  endtask
  // ====
  // scenarios
  task automatic t_route();
    primary_sector_selects <= 8'h01;
    secondary_sector_selects <= 4'h1;
    sram_select <= 1'b1;
    rdc("sram first", 8'h33);
    sram_select <= 1'b0;
    io_select <= 1'b1;
    rdc("io first", 8'h44);
    io_select <= 1'b0;
    rdc("secondary next", 8'h22);
    secondary_sector_selects <= 4'h0;
    rdc("primary last", 8'h11);
  endtask
  task automatic t_abort();
    wr(ADDR_UNLOCK1, CMD_UNLOCK1);
    wr(ADDR_UNLOCK2, CMD_UNLOCK2);
    wr(ADDR_UNLOCK1, CMD_ERASE_SETUP);
    wr(ADDR_UNLOCK1, 8'h77);
    wr(ADDR_UNLOCK2, CMD_UNLOCK2);
    wr(ADDR_UNLOCK1, CMD_BULK);
    settle();
    chk1("bad sequence", 1'b0, erasing);
    wr(12'h000, CMD_SUSPEND);
    rdc("idle suspend", 8'h11);
  endtask
  task automatic t_bulk();
    logic [7:0] v, v2;
    erase_cmd(ADDR_UNLOCK1, CMD_BULK);
    wait_flag(0, 1'b1, 4);
    wr(12'h000, CMD_RESET);
    rd(v);
    rd(v2);
    chk1("bulk ignores reset", 1'b1, erasing);
    chk1("toggle inverts", ~v[BIT_TOGGLE], v2[BIT_TOGGLE]);
    chk("bulk status", 12'h008, {4'h0, v2 & 8'hBF});
    wait_flag(0, 1'b0, 400);
    rdc("after bulk", 8'h11);
  endtask
  task automatic t_sector();
    logic [7:0] v;
    primary_sector_selects <= 8'h02;
    erase_cmd(12'h000, CMD_SECTOR);
    settle();
    chk("first queued", 12'h002, erase_sector_mask);
    rd(v);
    chk1("window flag", 1'b0, v[BIT_TIMEOUT]);
    primary_sector_selects <= 8'h04;
    wr(12'h000, CMD_SECTOR);
    repeat (36) @(posedge clk);
    primary_sector_selects <= 8'h08;
    wr(12'h000, CMD_SECTOR);
    repeat (30) @(posedge clk);
    #1;
    chk("queue", 12'h00A, erase_sector_mask);
    chk1("window restarted", 1'b0, erasing);
    wait_flag(0, 1'b1, 40);
    rd(v);
    chk1("erase flag", 1'b1, v[BIT_TIMEOUT]);
    wr(12'h000, 8'h55);
    chk1("erase ignores", 1'b1, erasing);
    primary_sector_selects <= 8'h02;
    wr(12'h010, CMD_SUSPEND);
    repeat (110) @(posedge clk);
    rdc("suspended sector", INVALID_DATA);
    rdc("suspended again", INVALID_DATA);
    primary_sector_selects <= 8'h01;
    rdc("other sector", 8'h11);
    wr(12'h000, 8'h55);
    primary_sector_selects <= 8'h02;
    rdc("still suspended", INVALID_DATA);
    wr(12'h020, CMD_RESUME);
    wait_flag(0, 1'b1, 10);
    settle();
    chk1("resume keeps erasing", 1'b1, erasing);
    wait_flag(0, 1'b0, 400);
    rdc("after sector erase", 8'h11);
  endtask
  task automatic t_window();
    erase_cmd(12'h000, CMD_SECTOR);
    wr(12'h000, 8'h55);
    settle();
    chk("window aborted", 12'h000, erase_sector_mask);
    erase_cmd(12'h000, CMD_SECTOR);
    wr(12'h000, CMD_SUSPEND);
    repeat (150) @(posedge clk);
    #1;
    chk1("window ended", 1'b0, erasing);
    rdc("window suspended", INVALID_DATA);
    wr(12'h000, CMD_RESET);
    settle();
    chk("reset clears", 12'h000, erase_sector_mask);
    erase_cmd(12'h000, CMD_SECTOR);
    wait_flag(0, 1'b1, 60);
    wr(12'h000, CMD_RESET);
    chk1("reset aborts sector", 1'b0, erasing);
    repeat (RECOVER_CYC + 2) @(posedge clk);
    #1;
    chk("sector recovered", 12'h000, erase_sector_mask);
  endtask
  task automatic t_fail();
    logic [7:0] v;
    fail_all <= 1'b1;
    erase_cmd(12'h000, CMD_SECTOR);
    wait_flag(1, 1'b1, 800);
    rd(v);
    chk("fail status", 12'h028, {4'h0, v & 8'hBF});
    fail_all <= 1'b0;
    wr(ADDR_UNLOCK1, CMD_UNLOCK1);
    wr(ADDR_UNLOCK2, CMD_UNLOCK2);
    wr(12'h000, CMD_RESET);
    wait_flag(1, 1'b0, RECOVER_CYC + 10);
    rdc("after error", 8'h11);
  endtask
  task automatic t_pin();
    erase_cmd(ADDR_UNLOCK1, CMD_BULK);
    wait_flag(0, 1'b1, 4);
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk1("pin aborts", 1'b0, erasing);
    reset_pin_n <= 1'b1;
    repeat (RECOVER_CYC + 10) @(posedge clk);
    rdc("after pin", 8'h11);
  endtask
  // ====
  // run
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {resetn, wr_strobe, rd_strobe, sram_select, io_select, fail_all} = 6'h00;
    {addr, wdata, primary_sector_selects, secondary_sector_selects} = 32'h0;
    reset_pin_n = 1'b1;
    sector_protect = 12'h004;
    miscompares = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_route();
    t_abort();
    t_bulk();
    t_sector();
    t_window();
    t_fail();
    t_pin();
    final_report();
  end
endmodule
